/* logic/dsp_chain_ctrl.sv */
// Onboard DSP chain: register slave, fetch pacing, pulse shaping, shift
// Function
// R1 - Controller sets mode, enable, data mode, rate, shift, filter before use.
// R2 - Generation mode resets to baseband; IF is the other choice.
// R3 - Baseband filters and interpolates; I on channel 0, Q on channel 1.
// R4 - Chain features act only when enabled; otherwise samples pass straight.
// R5 - Real data uses only the I path; Q path idles.
// R6 - Complex data runs both I and Q paths.
// R7 - One memory entry per I/Q rate period: pair or single sample.
// R8 - Output sample rate writes refused while enabled; rate then derived.
// R9 - Frequency shift applies only in baseband mode.
// R10 - Real single-channel output may be used directly, frequency shifted.
// R11 - Filter choices are flat, raised cosine and root raised cosine.
// R12 - External clock: select source, set rate, read rate, program, confirm.
// R13 - Real interpolation setup order is fixed before waveform download.
// R14 - New sample accepted once every total-interpolation sample clocks.
// R15 - Shift is a complex multiply by an NCO at the sample clock.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dsp_chain_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   mem_valid,
  output logic                        mem_ready,
  input  wire dsp_chain_pkg::sample_s mem_data,
  output dsp_chain_pkg::sample_s      dac_data,
  output logic                        dac_valid
);
  import dsp_chain_pkg::*;

  typedef struct packed {
    logic        en;
    gen_mode_e   mode;
    data_mode_e  dmode;
    filt_e       filt;
    logic        carrier;
    logic [15:0] iq_div;
    logic [15:0] sample_div;
    logic [31:0] fshift;
    logic        refused;
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic        primed;
    sample_s     cur;
    sample_s     prev;
    sample_s     fout;
    logic        fvalid;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic        fetch;
  logic        take;
  logic        wr_go;
  logic        rd_go;
  logic        shift_on;
  logic [15:0] div;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  sample_s     mix_out;
  logic        mix_vld;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old[8*b +: 8] = nw[8*b +: 8];
    end
    merge = old;
  endfunction

  // Pulse shaping on the held sample; sums widened to avoid wrap
  function automatic logic signed [15:0] shape(input filt_e f, input logic signed [15:0] c,
                                               input logic signed [15:0] p);
    logic signed [17:0] acc;
    acc = 18'(c);
    unique case (f)
      FILT_FLAT: acc = 18'(c);                                // R11
      FILT_RC:   acc = (18'(c) + 18'(p)) >>> 1;               // R11
      FILT_RRC:  acc = (18'(c) + 18'(c) + 18'(c) + 18'(p)) >>> 2; // R11
      default:   acc = 18'(c);
    endcase
    shape = acc[15:0];
  endfunction

  // Bus strobes: one wait cycle, then the access completes
  assign rd_go           = avs_read && s_q.ack;
  assign wr_go           = avs_write && s_q.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata    = s_q.rdata;

  // Pacing divider: I/Q period when enabled, plain sample divider otherwise
  assign div       = s_q.en ? s_q.iq_div : s_q.sample_div;        // R4 R14
  assign fetch     = (s_q.cnt == 16'h0000);                       // R7 R14
  assign mem_ready = fetch;
  assign take      = fetch && mem_valid;
  assign shift_on  = s_q.en && s_q.mode == GEN_BASEBAND && s_q.fshift != FSHIFT_RST; // R9

  // Read views of control and status
  always_comb begin
    ctrl_rd                 = 32'h0000_0000;
    ctrl_rd[CTRL_EN_BIT]    = s_q.en;
    ctrl_rd[CTRL_MODE_BIT]  = s_q.mode;
    ctrl_rd[CTRL_DMODE_BIT] = s_q.dmode;
    ctrl_rd[CTRL_FILT_LSB +: 2] = s_q.filt;
    ctrl_rd[CTRL_CARR_BIT]  = s_q.carrier;
    stat_rd                 = 32'h0000_0000;
    stat_rd[STAT_EN_BIT]    = s_q.en;
    stat_rd[STAT_REF_BIT]   = s_q.refused;
    stat_rd[STAT_PRIME_BIT] = s_q.primed;
    stat_rd[STAT_SHIFT_BIT] = shift_on;
  end

  // Next state of registers, pacing and datapath
  always_comb begin
    logic [31:0] w;
    w   = 32'h0000_0000;
    s_d = s_q;
    s_d.ack = (avs_read || avs_write) && !s_q.ack;
    if (avs_read && !s_q.ack) begin
      unique case (avs_address)
        OFS_CTRL:       s_d.rdata = ctrl_rd;
        OFS_IQ_DIV:     s_d.rdata = {16'h0000, s_q.iq_div};
        OFS_SAMPLE_DIV: s_d.rdata = {16'h0000, s_q.en ? DERIVED_RATE : s_q.sample_div}; // R8
        OFS_FSHIFT:     s_d.rdata = s_q.fshift;
        OFS_STATUS:     s_d.rdata = stat_rd;
        default:        s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      unique case (avs_address)
        OFS_CTRL: begin
          w         = merge(ctrl_rd, avs_writedata, avs_byteenable);
          s_d.en    = w[CTRL_EN_BIT];
          s_d.mode  = gen_mode_e'(w[CTRL_MODE_BIT]);          // R2
          s_d.dmode = data_mode_e'(w[CTRL_DMODE_BIT]);
          s_d.filt  = (w[CTRL_FILT_LSB +: 2] == 2'h3) ? FILT_FLAT
                                                      : filt_e'(w[CTRL_FILT_LSB +: 2]);
          s_d.carrier = w[CTRL_CARR_BIT];
        end
        OFS_IQ_DIV: begin
          w          = merge({16'h0000, s_q.iq_div}, avs_writedata, avs_byteenable);
          s_d.iq_div = w[15:0];
        end
        OFS_SAMPLE_DIV: begin
          // Enabled chain owns the output rate
          if (s_q.en) begin
            s_d.refused = 1'b1;                               // R8
          end else begin
            w              = merge({16'h0000, s_q.sample_div}, avs_writedata, avs_byteenable);
            s_d.sample_div = w[15:0];
          end
        end
        OFS_FSHIFT: s_d.fshift = merge(s_q.fshift, avs_writedata, avs_byteenable);
        OFS_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[STAT_REF_BIT]) s_d.refused = 1'b0;
        end
        default: s_d.fshift = s_q.fshift;
      endcase
    end
    // Set wins over a same-cycle clear
    if (wr_go && avs_address == OFS_SAMPLE_DIV && s_q.en) s_d.refused = 1'b1;

    // Fetch counter: waits at zero until memory offers an entry
    if (take) s_d.cnt = (div == 16'h0000) ? 16'h0000 : div - 16'h0001; // R7 R14
    else if (!fetch) s_d.cnt = s_q.cnt - 16'h0001;

    if (take) begin
      s_d.primed = 1'b1;
      s_d.prev   = s_q.cur;
      s_d.cur.i  = mem_data.i;
      // Real data leaves the Q path idle while the chain is enabled
      s_d.cur.q  = (s_q.en && s_q.dmode == DATA_REAL) ? 16'sh0000 : mem_data.q; // R5 R6
    end
    if (!s_q.en) s_d.primed = take ? 1'b1 : 1'b0;

    // Enabled: held sample is shaped every clock (interpolation by hold)
    if (s_q.en) begin
      s_d.fout.i = shape(s_q.filt, s_q.cur.i, s_q.prev.i);   // R3
      s_d.fout.q = shape(s_q.filt, s_q.cur.q, s_q.prev.q);   // R3 R6
      s_d.fvalid = s_q.primed;                                // R3 R14
    end else begin
      s_d.fout   = take ? mem_data : s_q.fout;                // R4
      s_d.fvalid = take;                                      // R4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q            <= '0;
      s_q.mode       <= GEN_BASEBAND;                          // R2
      s_q.dmode      <= DATA_REAL;
      s_q.filt       <= FILT_FLAT;
      s_q.iq_div     <= IQ_DIV_RST;
      s_q.sample_div <= SAMPLE_DIV_RST;
      s_q.fshift     <= FSHIFT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Shifter sits after the filter; real data gives a shifted output on both I and Q
  freq_shift_mixer u_mix (                                    // R10 R15
    .clk       (clk),
    .rst_n     (rst_n),
    .shift_en  (shift_on),
    .phase_inc (s_q.fshift),
    .din       (s_q.fout),
    .din_valid (s_q.fvalid),
    .dout      (mix_out),
    .dout_valid(mix_vld)
  );

  assign dac_data  = mix_out;
  assign dac_valid = mix_vld;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reset_mode;
    !$past(rst_n) |-> s_q.mode == GEN_BASEBAND && !s_q.en;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not baseband after reset"); // R2

  property p_fetch_spacing;
    take && s_q.en && s_q.iq_div > 16'h0001 |=> !mem_ready;
  endproperty
  a_fetch_spacing: assert property (p_fetch_spacing) else $error("fetch too soon"); // R7

  property p_fetch_period;
    take && s_q.en && s_q.iq_div == 16'h0003 && !wr_go |=> !mem_ready [*2] ##1 mem_ready;
  endproperty
  a_fetch_period: assert property (p_fetch_period) else $error("period of 3 broken"); // R14

  property p_rate_refused;
    wr_go && avs_address == OFS_SAMPLE_DIV && s_q.en |=> $stable(s_q.sample_div) && s_q.refused;
  endproperty
  a_rate_refused: assert property (p_rate_refused) else $error("rate write accepted"); // R8

  property p_real_q_idle;
    take && s_q.en && s_q.dmode == DATA_REAL |=> s_q.cur.q == 16'sh0000;
  endproperty
  a_real_q_idle: assert property (p_real_q_idle) else $error("Q path used in real mode"); // R5

  property p_complex_q;
    take && s_q.en && s_q.dmode == DATA_COMPLEX |=> s_q.cur.q == $past(mem_data.q);
  endproperty
  a_complex_q: assert property (p_complex_q) else $error("Q sample lost"); // R6

  property p_passthru;
    take && !s_q.en && !shift_on |=> ##1 dac_valid && dac_data == $past(mem_data, 2);
  endproperty
  a_passthru: assert property (p_passthru) else $error("disabled path not direct"); // R4

  property p_no_shift_if;
    s_q.en && s_q.mode == GEN_IF |=> dac_data == $past(s_q.fout);
  endproperty
  a_no_shift_if: assert property (p_no_shift_if) else $error("shift applied in IF mode"); // R9

  property p_flat;
    s_q.en && s_q.filt == FILT_FLAT |=> s_q.fout == $past(s_q.cur);
  endproperty
  a_flat: assert property (p_flat) else $error("flat response altered data"); // R11

  property p_bb_stream;
    s_q.en && s_q.primed |=> ##1 dac_valid;
  endproperty
  a_bb_stream: assert property (p_bb_stream) else $error("baseband output stalled"); // R3

  property p_rate_readback;
    rd_go && avs_address == OFS_SAMPLE_DIV && s_q.en
      |-> avs_readdata == {16'h0000, DERIVED_RATE};
  endproperty
  a_rate_readback: assert property (p_rate_readback) else $error("derived rate not shown"); // R8

  property p_pair_taken;
    take && s_q.en && s_q.dmode == DATA_COMPLEX |=> s_q.cur == $past(mem_data);
  endproperty
  a_pair_taken: assert property (p_pair_taken) else $error("complex pair split"); // R7

  // Steady input must leave every response at unity gain
  property p_unity_steady;
    s_q.en && s_q.cur == s_q.prev |=> s_q.fout == $past(s_q.cur);
  endproperty
  a_unity_steady: assert property (p_unity_steady) else $error("filter gain not unity"); // R11

  property p_refused_sticky;
    s_q.refused && !(wr_go && avs_address == OFS_STATUS) |=> s_q.refused;
  endproperty
  a_refused_sticky: assert property (p_refused_sticky) else $error("refused flag lost"); // R8

  c_complex_fetch: cover property (take && s_q.en && s_q.dmode == DATA_COMPLEX);
  c_refused:       cover property (wr_go && avs_address == OFS_SAMPLE_DIV && s_q.en);
  c_shift:         cover property (shift_on && dac_valid);
  c_plain:         cover property (take && !s_q.en);
  c_rrc:           cover property (s_q.en && s_q.filt == FILT_RRC && s_q.fvalid);
endmodule
`default_nettype wire

/* logic/dsp_chain_pkg.sv */
// Constants, modes and filter types of the onboard DSP chain
package dsp_chain_pkg;
  // Register byte offsets
  localparam logic [4:0]  OFS_CTRL       = 5'h00;
  localparam logic [4:0]  OFS_IQ_DIV     = 5'h04;
  localparam logic [4:0]  OFS_SAMPLE_DIV = 5'h08;
  localparam logic [4:0]  OFS_FSHIFT     = 5'h0C;
  localparam logic [4:0]  OFS_STATUS     = 5'h10;
  // Control field positions
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_MODE_BIT  = 1;
  localparam int          CTRL_DMODE_BIT = 2;
  localparam int          CTRL_FILT_LSB  = 3;
  localparam int          CTRL_CARR_BIT  = 5;
  // Status field positions
  localparam int          STAT_EN_BIT    = 0;
  localparam int          STAT_REF_BIT   = 1;
  localparam int          STAT_PRIME_BIT = 2;
  localparam int          STAT_SHIFT_BIT = 3;
  // Reset values, derived rate and sample width
  localparam logic [15:0] IQ_DIV_RST     = 16'h0001;
  localparam logic [15:0] SAMPLE_DIV_RST = 16'h0001;
  localparam logic [31:0] FSHIFT_RST     = 32'h0000_0000;
  localparam logic [15:0] DERIVED_RATE   = 16'h0001;
  localparam int          SAMPLE_W       = 16;

  typedef enum logic {
    GEN_BASEBAND = 1'b0,
    GEN_IF       = 1'b1
  } gen_mode_e;

  typedef enum logic {
    DATA_REAL    = 1'b0,
    DATA_COMPLEX = 1'b1
  } data_mode_e;

  typedef enum logic [1:0] {
    FILT_FLAT = 2'b00,
    FILT_RC   = 2'b01,
    FILT_RRC  = 2'b10
  } filt_e;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } sample_s;
endpackage

/* logic/freq_shift_mixer.sv */
// Complex frequency shifter: phase accumulator, sine table, complex multiply
`timescale 1ns/1ps
`default_nettype none
module freq_shift_mixer (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  shift_en,
  input  wire logic [31:0]           phase_inc,
  input  wire dsp_chain_pkg::sample_s din,
  input  wire logic                  din_valid,
  output dsp_chain_pkg::sample_s     dout,
  output logic                       dout_valid
);
  import dsp_chain_pkg::*;

  typedef struct packed {
    logic [31:0] phase;
    sample_s     out;
    logic        vld;
  } mix_state_s;

  mix_state_s s_q;
  mix_state_s s_d;

  // Sine of 16 phase steps built from a quarter-wave table
  function automatic logic signed [15:0] sine16(input logic [3:0] k);
    logic [1:0]  m;
    logic [15:0] mag;
    m = k[1:0];
    if (k[2]) m = 2'(3'h4 - {1'b0, k[1:0]});
    unique case (m)
      2'h0: mag = k[2] ? 16'h7FFF : 16'h0000;
      2'h1: mag = 16'h30FB;
      2'h2: mag = 16'h5A82;
      2'h3: mag = 16'h7641;
    endcase
    if (k[2] && k[1:0] == 2'h0) mag = 16'h7FFF;
    sine16 = k[3] ? -$signed(mag) : $signed(mag);
  endfunction

  // NCO advances every sample clock while shift is on, else held at zero; output always one register late
  always_comb begin
    logic signed [15:0] c;
    logic signed [15:0] sn;
    logic signed [32:0] re;
    logic signed [32:0] im;
    c  = sine16(4'(s_q.phase[31:28] + 4'h4));
    sn = sine16(s_q.phase[31:28]);
    re = 33'(din.i * c) - 33'(din.q * sn);                   // R15
    im = 33'(din.i * sn) + 33'(din.q * c);                   // R15
    s_d     = s_q;
    s_d.vld = din_valid;
    if (shift_en) begin
      s_d.phase = s_q.phase + phase_inc;
      s_d.out.i = re[30:15];
      s_d.out.q = im[30:15];
    end else begin
      s_d.phase = 32'h0000_0000;
      s_d.out   = din;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign dout       = s_q.out;
  assign dout_valid = s_q.vld;

  property p_mix_bypass;
    @(posedge clk) disable iff (!rst_n)
      !shift_en |=> dout == $past(din) && dout_valid == $past(din_valid);
  endproperty
  a_mix_bypass: assert property (p_mix_bypass) else $error("bypass not transparent"); // R15
endmodule
`default_nettype wire

/* testbench/wave_mem_model.sv */
// Waveform memory model feeding the DSP chain one entry per handshake
`timescale 1ns/1ps
`default_nettype none
module wave_mem_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   run,
  input  wire logic                   step,
  input  wire logic [31:0]            base,
  input  wire logic                   mem_ready,
  output logic                        mem_valid,
  output dsp_chain_pkg::sample_s      mem_data
);
  import dsp_chain_pkg::*;
  logic [31:0] nxt;

  // Offer held until taken; an idle bus shows inverted data, never stale data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      mem_data  <= '0;
      nxt       <= '0;
    end else if (!mem_valid || mem_ready) begin
      mem_valid <= run;
      // Invert once on release, then hold: stale data never reappears
      mem_data  <= run ? (step ? nxt : base) : (mem_valid ? ~mem_data : mem_data);
      if (!run) begin
        nxt <= base;
      end else if (step) begin
        nxt <= nxt + 32'h0001_0001;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the onboard DSP chain controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsp_chain_pkg::*;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        mem_valid, mem_ready, dac_valid, run, step, pass_chk;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, base, rd;
  sample_s     mem_data, dac_data;
  sample_s     q_exp[$];
  int          miscompares = 0, tests_run = 0, cyc = 0, last_fetch = 0, fetch_gap = 0;

  dsp_chain_ctrl i_dsp_chain_ctrl (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_data(mem_data), .dac_data(dac_data), .dac_valid(dac_valid));
  wave_mem_model i_wave_mem_model (.clk(clk), .rst_n(rst_n), .run(run), .step(step),
    .base(base), .mem_ready(mem_ready), .mem_valid(mem_valid), .mem_data(mem_data));

  // 200 MHz sample clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Fetch spacing, pass-through scoreboard and run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
    if (mem_valid && mem_ready) begin
      fetch_gap  <= cyc - last_fetch;
      last_fetch <= cyc;
      if (pass_chk) q_exp.push_back(mem_data);
    end
    if (pass_chk && dac_valid && q_exp.size() > 0) chk(dac_data, q_exp.pop_front());
  end

  // One Avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) miscompares++;
    // Read data taken at the same edge that ends the wait
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(rd & m, e);
  endtask

  task automatic t_reset();
    rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdchk(OFS_IQ_DIV, 32'hFFFF_FFFF, {16'h0, IQ_DIV_RST});
    rdchk(OFS_SAMPLE_DIV, 32'hFFFF_FFFF, {16'h0, SAMPLE_DIV_RST});
    rdchk(OFS_FSHIFT, 32'hFFFF_FFFF, FSHIFT_RST);
    rdchk(OFS_STATUS, 32'hFFFF_FFFF, 32'h0);
    rdchk(5'h14, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, OFS_FSHIFT, 32'hAAAA_5555, 4'h3);
    rdchk(OFS_FSHIFT, 32'hFFFF_FFFF, 32'h0000_5555);
    wr(OFS_FSHIFT, 32'h0);
    // Carrier stored, filter code 3 falls back to flat
    wr(OFS_CTRL, 32'h3E);
    rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h26);
    wr(OFS_CTRL, 32'h0);
    $display("test reset_values done");
  endtask

  // Disabled chain: plain divider paces fetches, samples pass unchanged
  task automatic t_pass();
    wr(OFS_SAMPLE_DIV, 32'h3);
    rdchk(OFS_SAMPLE_DIV, 32'hFFFF_FFFF, 32'h3);
    base     <= 32'h1000_2000;
    step     <= 1'b1;
    pass_chk <= 1'b1;
    run      <= 1'b1;
    repeat (40) @(posedge clk);
    chk(fetch_gap, 32'd3);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    pass_chk <= 1'b0;
    chk(q_exp.size(), 32'd0);
    $display("test passthrough done");
  endtask

  task automatic t_refuse();
    wr(OFS_CTRL, 32'h1);
    wr(OFS_IQ_DIV, 32'h4);
    wr(OFS_SAMPLE_DIV, 32'h7);
    rdchk(OFS_SAMPLE_DIV, 32'hFFFF_FFFF, {16'h0, DERIVED_RATE});
    rdchk(OFS_STATUS, 32'h3, 32'h3);
    wr(OFS_STATUS, 32'h2);
    rdchk(OFS_STATUS, 32'h2, 32'h0);
    base <= 32'h0400_0C00;
    step <= 1'b0;
    run  <= 1'b1;
    repeat (30) @(posedge clk);
    chk(fetch_gap, 32'd4);
    rdchk(OFS_STATUS, 32'h4, 32'h4);
    $display("test refused_rate done");
  endtask

  // Every filter with real and complex data on a steady input
  task automatic t_filt();
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 2; c++) begin
        wr(OFS_CTRL, 32'h1 | (c << CTRL_DMODE_BIT) | (f << CTRL_FILT_LSB));
        repeat (20) @(posedge clk);
        chk(dac_valid, 32'h1);
        chk(dac_data, c ? 32'h0400_0C00 : 32'h0400_0000);
      end
    end
    $display("test filters done");
  endtask

  task automatic t_shift();
    logic nz;
    nz = 1'b0;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_FSHIFT, 32'h1000_0000);
    rdchk(OFS_STATUS, 32'h9, 32'h9);
    repeat (16) begin
      @(posedge clk);
      nz = nz | (dac_data.q != 16'h0);
    end
    chk(nz, 32'h1);
    wr(OFS_CTRL, 32'h3);
    rdchk(OFS_STATUS, 32'h9, 32'h1);
    repeat (20) @(posedge clk);
    chk(dac_data, 32'h0400_0000);
    run <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    $display("test freq_shift done");
  endtask

  // Reset while enabled with memory stopped: IF mode and enable must fall back to defaults
  task automatic t_rereset();
    wr(OFS_CTRL, 32'h3);
    rdchk(OFS_STATUS, 32'h1, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
    rdchk(OFS_IQ_DIV, 32'hFFFF_FFFF, {16'h0, IQ_DIV_RST});
    $display("test mid_reset done");
  endtask

  // Reset, then the scenarios in order
  initial begin
    rst_n          = 1'b0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 5'h00;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'h0;
    run            = 1'b0;
    step           = 1'b0;
    base           = 32'h0;
    pass_chk       = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pass();
    t_refuse();
    t_filt();
    t_shift();
    t_rereset();
    end_of_test();
  end
endmodule
`default_nettype wire
